// *** hw/stmr_compare.sv ***
// comparators of the standard timer: full compare-a and coarse compare-p
`timescale 1ns/1ps
`default_nettype none
module stmr_compare
  import stmr_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic [CW-1:0] count,
  input wire logic [CW-1:0] cmp_a,
  input wire logic [7:0] cmp_p,
  input wire logic running,
  output stmr_match_s match
);
  // all counter bits against the full value, only while counting
  assign match.match_a = running && (count == cmp_a); // [RQ22]
  // coarse value meets the upper byte one clock before it rolls over, so the
  // period comes out as value times 256; zero is left to the overflow path
  assign match.match_p = running && (cmp_p != 8'h00) &&
    (count[CW-1:CW-8] == cmp_p - 8'h01) && (count[CW-9:0] == '1); // [RQ1]
  assign match.overflow = running && (count == '1); // [RQ2]
endmodule
`default_nettype wire

// *** hw/stmr_pkg.sv ***
// package for the standard timer: register map, field layout, modes
package stmr_pkg;
  localparam int STMR_AW = 4;
  // register offsets (word index on the plain port)
  localparam logic [3:0] STMR_OFS_CTRL0 = 4'h0;
  localparam logic [3:0] STMR_OFS_CTRL1 = 4'h1;
  localparam logic [3:0] STMR_OFS_CNT_LO = 4'h2;
  localparam logic [3:0] STMR_OFS_CNT_HI = 4'h3;
  localparam logic [3:0] STMR_OFS_CMPA_LO = 4'h4;
  localparam logic [3:0] STMR_OFS_CMPA_HI = 4'h5;
  localparam logic [3:0] STMR_OFS_PERIOD = 4'h6;
  localparam logic [3:0] STMR_OFS_FLAGS = 4'h7;
  // control 0 field positions
  localparam int STMR_C0_PAUSE = 7;
  localparam int STMR_C0_ENABLE = 3;
  // control 1 field positions
  localparam int STMR_C1_MODE_HI = 7;
  localparam int STMR_C1_MODE_LO = 6;
  localparam int STMR_C1_OF_HI = 5;
  localparam int STMR_C1_OF_LO = 4;
  localparam int STMR_C1_INIT = 3;
  localparam int STMR_C1_INV = 2;
  localparam int STMR_C1_SWAP = 1;
  localparam int STMR_C1_CLRSEL = 0;
  // flag register field positions
  localparam int STMR_FL_A = 0;
  localparam int STMR_FL_P = 1;
  // reset values and the 65536 full period length
  localparam logic [7:0] STMR_RST_BYTE = 8'h00;
  localparam logic [15:0] STMR_RST_CNT = 16'h0000;
  localparam logic [16:0] STMR_FULL_PERIOD = 17'h10000;
  typedef enum logic [1:0] {
    STMR_MODE_CMP = 2'b00,
    STMR_MODE_CAP = 2'b01,
    STMR_MODE_PWM = 2'b10,
    STMR_MODE_TMR = 2'b11
  } stmr_mode_e;
  typedef enum logic [1:0] {
    STMR_OF_00 = 2'b00,
    STMR_OF_01 = 2'b01,
    STMR_OF_10 = 2'b10,
    STMR_OF_11 = 2'b11
  } stmr_of_e;
  // decoded control fields
  typedef struct packed {
    stmr_mode_e mode;
    stmr_of_e out_fn;
    logic init_level;
    logic invert;
    logic swap;
    logic clr_sel;
  } stmr_ctrl_s;
  // match events from the comparator
  typedef struct packed {
    logic match_a;
    logic match_p;
    logic overflow;
  } stmr_match_s;
endpackage

// *** hw/stmr_timer.sv ***
// standard timer top: registers, counter, flags and output pin
// Overview of operation
// RQ1: compare-p checks counter bits 15..8; period 256 times value, 65536 when zero.
// RQ2: compare-p zero lets the counter overflow; overflow is the clear event.
// RQ3: compare-a high byte is read/write, resets to zero, joins low byte.
// RQ4: mode 00 compare output, 11 timer/counter, 10 with function 10 pwm.
// RQ5: compare mode, clear-select low: clear on p match or overflow, both flags.
// RQ6: compare mode, clear-select high: clear on a match, only the a flag.
// RQ7: software never sets compare-a to zero in compare output mode.
// RQ8: compare mode pin changes only on a compare-a match, never on p.
// RQ9: enable rise loads initial level; function zero makes no pin change.
// RQ10: on a match: 00 no change, 01 low, 10 high, 11 toggle.
// RQ11: enable rise clears counter; enable fall stops and keeps the count.
// RQ12: timer/counter mode counts and flags like compare mode, pin unused.
// RQ13: pwm ignores clear-select; swap bit picks period and duty source.
// RQ14: pwm raises each flag on each of its own matches.
// RQ15: pwm uses initial level as polarity, function as enable, invert flips.
// RQ16: pwm function 00 inactive, 01 active, 10 waveform, 11 single pulse; the code drives 11 inactive instead.
// RQ17: swap zero: period compare-p times 256 or 65536, duty compare-a.
// RQ18: duty at or above the period gives full duty.
// RQ19: swap one: period from compare-a, duty compare-p times 256, zero 65536.
// RQ20: forced levels 00 or 01 keep the pwm counting and comparing.
// RQ21: pwm active from clear until duty match, then inactive until clear.
// RQ22: compare-a uses all 16 bits, matches only while enabled and running.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module stmr_timer
  import stmr_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [STMR_AW-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic timer_tick,
  output logic [7:0] rdata,
  output logic timer_output_pin,
  output logic timer_output_pin_oe_b,
  output logic compare_a_flag,
  output logic compare_p_flag
);
  logic [7:0] ctrl0_ff;
  logic [7:0] ctrl1_ff;
  logic [7:0] cmpa_lo_ff;
  logic [7:0] compare_a_high_byte_ff;
  logic [7:0] period_compare_coarse_ff;
  logic [CW-1:0] count_ff;
  logic enable_d_ff;
  logic tick_s1_ff;
  logic tick_s2_ff;
  logic tick_d_ff;
  logic flag_a_ff;
  logic flag_p_ff;
  logic pin_ff;
  logic pwm_ff;
  logic counter_enable;
  logic paused;
  logic tick;
  logic running;
  logic enable_rise;
  logic do_clear;
  logic wr_flags;
  logic [CW-1:0] compare_a_value;
  logic [CW:0] period_len;
  logic [CW:0] duty_len;
  logic full_duty;
  logic duty_hit;
  logic nxt_pin;
  logic nxt_out;
  stmr_ctrl_s ctrl;
  stmr_match_s match;
  logic [7:0] nxt_rdata;

  assign counter_enable = ctrl0_ff[STMR_C0_ENABLE];
  assign paused = ctrl0_ff[STMR_C0_PAUSE];
  assign ctrl.mode = stmr_mode_e'(ctrl1_ff[STMR_C1_MODE_HI:STMR_C1_MODE_LO]); // [RQ4]
  assign ctrl.out_fn = stmr_of_e'(ctrl1_ff[STMR_C1_OF_HI:STMR_C1_OF_LO]);
  assign ctrl.init_level = ctrl1_ff[STMR_C1_INIT];
  assign ctrl.invert = ctrl1_ff[STMR_C1_INV];
  assign ctrl.swap = ctrl1_ff[STMR_C1_SWAP];
  assign ctrl.clr_sel = ctrl1_ff[STMR_C1_CLRSEL];
  // compare-a is the two bytes side by side
  assign compare_a_value = {compare_a_high_byte_ff, cmpa_lo_ff}; // [RQ3]
  assign enable_rise = counter_enable && !enable_d_ff;
  // the timer clock comes from outside, so only a synchronised edge counts
  assign tick = tick_s2_ff && !tick_d_ff;
  assign running = counter_enable && !paused && tick;
  assign wr_flags = wr_en && (addr == STMR_OFS_FLAGS);

  stmr_compare #(
    .CW(CW)
  ) u_cmp (
    .count(count_ff),
    .cmp_a(compare_a_value),
    .cmp_p(period_compare_coarse_ff),
    .running(running),
    .match(match)
  );

  // clear source: pwm follows the swap bit, other modes the clear-select bit
  always_comb begin
    if (ctrl.mode == STMR_MODE_PWM) begin
      do_clear = ctrl.swap ? match.match_a : (match.match_p || match.overflow); // [RQ13]
    end else if (ctrl.clr_sel) begin
      do_clear = match.match_a; // [RQ6]
    end else begin
      do_clear = match.match_p || match.overflow; // [RQ5] [RQ2]
    end
  end

  // external timer clock passes two flops before any edge detect
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tick_s1_ff <= 1'b0;
      tick_s2_ff <= 1'b0;
      tick_d_ff <= 1'b0;
    end else begin
      tick_s1_ff <= timer_tick;
      tick_s2_ff <= tick_s1_ff;
      tick_d_ff <= tick_s2_ff;
    end
  end

  // software registers; mode bits should only change with the timer off
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl0_ff <= STMR_RST_BYTE;
      ctrl1_ff <= STMR_RST_BYTE;
      cmpa_lo_ff <= STMR_RST_BYTE;
      compare_a_high_byte_ff <= STMR_RST_BYTE;
      period_compare_coarse_ff <= STMR_RST_BYTE;
    end else if (wr_en) begin
      unique case (addr)
        STMR_OFS_CTRL0: ctrl0_ff <= wdata & 8'hF8;
        STMR_OFS_CTRL1: ctrl1_ff <= wdata;
        STMR_OFS_CMPA_LO: cmpa_lo_ff <= wdata;
        STMR_OFS_CMPA_HI: compare_a_high_byte_ff <= wdata; // [RQ3]
        STMR_OFS_PERIOD: period_compare_coarse_ff <= wdata; // [RQ1]
        default: ;
      endcase
    end
  end

  // counter: enable rise restarts from zero, fall just freezes the value
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_ff <= STMR_RST_CNT;
      enable_d_ff <= 1'b0;
    end else begin
      enable_d_ff <= counter_enable;
      if (enable_rise) begin
        count_ff <= STMR_RST_CNT; // [RQ11]
      end else if (running) begin
        count_ff <= do_clear ? STMR_RST_CNT : count_ff + 1'b1; // [RQ2]
      end
    end
  end

  // sticky flags; a match in the same cycle as the clear write wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flag_a_ff <= 1'b0;
      flag_p_ff <= 1'b0;
    end else begin
      if (match.match_a) begin
        flag_a_ff <= 1'b1; // [RQ5] [RQ14]
      end else if (wr_flags && wdata[STMR_FL_A]) begin
        flag_a_ff <= 1'b0;
      end
      // p flag is suppressed only when a match clears in a non-pwm mode
      if ((match.match_p || match.overflow) &&
          (ctrl.mode == STMR_MODE_PWM || !ctrl.clr_sel)) begin
        flag_p_ff <= 1'b1; // [RQ6] [RQ14] [RQ12]
      end else if (wr_flags && wdata[STMR_FL_P]) begin
        flag_p_ff <= 1'b0;
      end
    end
  end

  // pwm lengths in timer clocks; a coarse value of zero stands for 65536
  always_comb begin
    logic [CW:0] coarse;
    coarse = (period_compare_coarse_ff == 8'h00) ? STMR_FULL_PERIOD :
      {1'b0, period_compare_coarse_ff, 8'h00};
    if (ctrl.swap) begin
      period_len = {1'b0, compare_a_value} + 1'b1; // [RQ19]
      duty_len = coarse;
    end else begin
      period_len = coarse; // [RQ17]
      duty_len = {1'b0, compare_a_value};
    end
  end
  assign full_duty = duty_len >= period_len; // [RQ18]
  // duty ends when the count reaches the duty length, regardless of source
  assign duty_hit = running && ({1'b0, count_ff} + 1'b1 == duty_len);

  // pwm state runs whatever the function field says
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pwm_ff <= 1'b0;
    end else if (enable_rise) begin
      pwm_ff <= 1'b1;
    end else if (running) begin
      if (do_clear || full_duty) begin
        pwm_ff <= 1'b1; // [RQ21] [RQ20]
      end else if (duty_hit) begin
        pwm_ff <= 1'b0; // [RQ21]
      end
    end
  end

  // compare mode pin level, loaded at enable rise, then changed only by compare-a matches
  always_comb begin
    nxt_pin = pin_ff;
    if (enable_rise) begin
      nxt_pin = ctrl.init_level; // [RQ9]
    end else if (match.match_a) begin
      unique case (ctrl.out_fn) // [RQ10] [RQ8]
        STMR_OF_00: nxt_pin = pin_ff;
        STMR_OF_01: nxt_pin = 1'b0;
        STMR_OF_10: nxt_pin = 1'b1;
        STMR_OF_11: nxt_pin = !pin_ff;
      endcase
    end
  end

  // pin drive per mode; single pulse is not built and reads inactive
  always_comb begin
    logic act;
    act = ctrl.init_level;
    nxt_out = 1'b0;
    unique case (ctrl.mode)
      STMR_MODE_CMP: nxt_out = nxt_pin ^ ctrl.invert;
      STMR_MODE_PWM: begin
        unique case (ctrl.out_fn) // [RQ16] [RQ15]
          STMR_OF_00: nxt_out = !act;
          STMR_OF_01: nxt_out = act;
          STMR_OF_10: nxt_out = pwm_ff ? act : !act;
          STMR_OF_11: nxt_out = !act;
        endcase
        nxt_out = nxt_out ^ ctrl.invert; // [RQ15]
      end
      STMR_MODE_CAP: nxt_out = 1'b0;
      STMR_MODE_TMR: nxt_out = 1'b0; // [RQ12]
    endcase
  end

  // output flops; the pin is released in timer/counter and capture modes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_ff <= 1'b0;
      timer_output_pin <= 1'b0;
      timer_output_pin_oe_b <= 1'b1;
    end else begin
      pin_ff <= nxt_pin;
      timer_output_pin <= nxt_out;
      timer_output_pin_oe_b <= !(ctrl.mode == STMR_MODE_CMP ||
        ctrl.mode == STMR_MODE_PWM); // [RQ12]
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 8'h00;
    unique case (addr)
      STMR_OFS_CTRL0: nxt_rdata = ctrl0_ff;
      STMR_OFS_CTRL1: nxt_rdata = ctrl1_ff;
      STMR_OFS_CNT_LO: nxt_rdata = count_ff[7:0];
      STMR_OFS_CNT_HI: nxt_rdata = count_ff[CW-1:CW-8];
      STMR_OFS_CMPA_LO: nxt_rdata = cmpa_lo_ff;
      STMR_OFS_CMPA_HI: nxt_rdata = compare_a_high_byte_ff;
      STMR_OFS_PERIOD: nxt_rdata = period_compare_coarse_ff;
      STMR_OFS_FLAGS: nxt_rdata = {6'h00, flag_p_ff, flag_a_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata <= 8'h00;
      compare_a_flag <= 1'b0;
      compare_p_flag <= 1'b0;
    end else begin
      rdata <= rd_en ? nxt_rdata : 8'h00;
      compare_a_flag <= flag_a_ff;
      compare_p_flag <= flag_p_ff;
    end
  end
endmodule
`default_nettype wire

// *** test/stmr_load.sv ***
// load on the timer output pin, pulled down when released
`timescale 1ns/1ps
`default_nettype none
module stmr_load (
  input wire logic pin,
  input wire logic oe_b,
  output logic level
);
  // a released pin falls to the pull-down instead of keeping its last value
  assign level = oe_b ? 1'b0 : pin;
endmodule
`default_nettype wire

// *** test/stmr_timer_asserts.sv ***
// port checker for the standard timer
`timescale 1ns/1ps
`default_nettype none
module stmr_timer_asserts
  import stmr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [STMR_AW-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic timer_tick,
  input wire logic [7:0] rdata,
  input wire logic timer_output_pin,
  input wire logic timer_output_pin_oe_b,
  input wire logic compare_a_flag,
  input wire logic compare_p_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // write-one-to-clear strobes for each flag
  logic clr_a;
  logic clr_p;
  assign clr_a = wr_en && addr == STMR_OFS_FLAGS && wdata[STMR_FL_A];
  assign clr_p = wr_en && addr == STMR_OFS_FLAGS && wdata[STMR_FL_P];
  // a mode write, then the pin output enable settles a cycle or two later
  sequence set_mode(m);
    wr_en && addr == STMR_OFS_CTRL1 && wdata[7:6] == m;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> !compare_a_flag && !compare_p_flag
    && timer_output_pin_oe_b && !timer_output_pin) else $error("state not cleared by reset");
  a_rdata_idle: assert property (!rd_en |=> rdata == 8'h00) else $error("read data without read");
  a_unmapped_zero: assert property (rd_en && addr > STMR_OFS_FLAGS |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl0_low: assert property (rd_en && addr == STMR_OFS_CTRL0 |=> rdata[2:0] == 3'h0)
    else $error("unused control bits not zero");
  a_fa_cleared: assert property ($fell(compare_a_flag) && $past(rst_b) |->
    $past(clr_a) || $past(clr_a, 2)) else $error("flag a dropped without clear");
  a_fp_cleared: assert property ($fell(compare_p_flag) && $past(rst_b) |->
    $past(clr_p) || $past(clr_p, 2)) else $error("flag p dropped without clear");
  a_tmr_pin_free: assert property (set_mode(2'b11) |-> ##[1:2] timer_output_pin_oe_b)
    else $error("pin still driven in timer mode");
  a_cmp_pin_on: assert property (set_mode(2'b00) |-> ##[1:2] !timer_output_pin_oe_b)
    else $error("pin not driven in compare mode");
  a_fa_after_tick: assert property ($rose(compare_a_flag) |-> $past(timer_tick, 2)
    || $past(timer_tick, 3) || $past(timer_tick, 4) || $past(timer_tick, 5))
    else $error("flag a rose without a count");
endmodule
`default_nettype wire

// *** test/stmr_timer_tb.sv ***
// self-checking bench for the standard timer
`timescale 1ns/1ps
`default_nettype none
module stmr_timer_tb;
  import stmr_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [STMR_AW-1:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic timer_tick = 1'b0;
  logic [7:0] rdata;
  logic pin;
  logic oe_b;
  logic fa;
  logic fp;
  logic level;
  int err_total = 0;
  int n_tests = 0;
  always #2 clk = ~clk;
  stmr_timer dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .timer_tick(timer_tick), .rdata(rdata), .timer_output_pin(pin),
    .timer_output_pin_oe_b(oe_b), .compare_a_flag(fa), .compare_p_flag(fp));
  stmr_load u_load (.pin(pin), .oe_b(oe_b), .level(level));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // slow ticks so the two-flop sync always sees both levels
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      timer_tick <= 1'b1;
      repeat (4) @(posedge clk);
      timer_tick <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  // restart with new settings, count, then check {oe_b, level, flag a, flag p}
  task automatic run(input logic [7:0] hi, lo, c, input int n, input logic [3:0] st);
    wr(STMR_OFS_CTRL0, 8'h00);
    wr(STMR_OFS_CMPA_HI, hi);
    wr(STMR_OFS_CMPA_LO, lo);
    wr(STMR_OFS_CTRL1, c);
    wr(STMR_OFS_FLAGS, 8'h03);
    wr(STMR_OFS_CTRL0, 8'h08);
    rd(STMR_OFS_CNT_LO, 8'h00);
    tick(n);
    repeat (8) @(posedge clk);
    #1 chk({4'h0, oe_b, level, fa, fp}, {4'h0, st});
  endtask
  task automatic close_out;
    $display("mismatches %0d, checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run of some seven thousand cycles
  initial begin
    #100000;
    err_total++;
    close_out();
  end
  // compare-a is kept nonzero whenever compare mode runs
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(STMR_OFS_CMPA_HI, 8'h00);
    rd(STMR_OFS_PERIOD, 8'h00);
    wr(STMR_OFS_CMPA_HI, 8'hA5);
    rd(STMR_OFS_CMPA_HI, 8'hA5);
    rd(4'hF, 8'h00);
    wr(STMR_OFS_PERIOD, 8'h01);
    rd(STMR_OFS_PERIOD, 8'h01);
    run(8'h01, 8'h05, 8'h39, 262, 4'b0010);
    run(8'h00, 8'h05, 8'h09, 6, 4'b0110);
    run(8'h00, 8'h05, 8'h19, 6, 4'b0010);
    run(8'h00, 8'h05, 8'h21, 6, 4'b0110);
    run(8'h00, 8'h05, 8'h38, 257, 4'b0011);
    run(8'h00, 8'h05, 8'hF8, 257, 4'b1011);
    run(8'h00, 8'h05, 8'h98, 3, 4'b0100);
    wr(STMR_OFS_CTRL0, 8'h00);
    tick(2);
    rd(STMR_OFS_CNT_LO, 8'h03);
    run(8'h00, 8'h05, 8'h88, 10, 4'b0010);
    run(8'h00, 8'h05, 8'h8C, 10, 4'b0110);
    run(8'h00, 8'h05, 8'hB8, 3, 4'b0000);
    run(8'h00, 8'h05, 8'hA8, 3, 4'b0100);
    run(8'h00, 8'h05, 8'hA9, 10, 4'b0010);
    run(8'h00, 8'h05, 8'hAA, 10, 4'b0110);
    close_out();
  end
endmodule
bind stmr_timer stmr_timer_asserts u_chk (.clk(clk), .rst_b(rst_b), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .timer_tick(timer_tick), .rdata(rdata),
  .timer_output_pin(timer_output_pin), .timer_output_pin_oe_b(timer_output_pin_oe_b),
  .compare_a_flag(compare_a_flag), .compare_p_flag(compare_p_flag));
`default_nettype wire
